// ---- dcc_regs.svh ----
// Register map, field positions and reset values of the comparator control.
// Included by the package file and dcc_top; definitions only.
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_ADDR_W        16
`define DCC_OFF_CTL1      16'hA000
`define DCC_OFF_CTL2      16'hA010
`define DCC_OFF_STAT      16'hA060
`define DCC_OFF_INTSTAT   16'hA070
`define DCC_OFF_INTMASK   16'hA080
`define DCC_ALIAS_CLR     2'h1
`define DCC_ALIAS_SET     2'h2
`define DCC_ALIAS_INV     2'h3

`define DCC_BIT_ENABLE    15
`define DCC_BIT_PINEN     14
`define DCC_BIT_INVERT    13
`define DCC_BIT_RESULT    8
`define DCC_BIT_EDGEHI    7
`define DCC_BIT_EDGELO    6
`define DCC_BIT_POSSEL    4
`define DCC_BIT_NEGHI     1
`define DCC_BIT_NEGLO     0
`define DCC_BIT_IDLESTOP  13

`define DCC_CTL_WMASK     32'h0000_E0D3
`define DCC_STAT_WMASK    32'h0000_2000
`define DCC_CTL_RESET     32'h0000_00C3
`define DCC_STAT_RESET    32'h0000_0000
`define DCC_INT_WMASK     32'h0000_0003

`endif

// ---- dcc_pkg.sv ----
// Types shared by the comparator control modules.
// Assumes dcc_regs.svh sits in the same folder.
`include "dcc_regs.svh"
package dcc_pkg;
    typedef logic [31:0] dcc_word_t;
    typedef enum logic [1:0] {
        DCC_NEG_OWN_NEG,
        DCC_NEG_OWN_POS,
        DCC_NEG_OTHER_POS,
        DCC_NEG_FIXED_REF
    } dcc_neg_sel_t;
    typedef enum logic [1:0] {
        DCC_EDGE_NONE,
        DCC_EDGE_RISE,
        DCC_EDGE_FALL,
        DCC_EDGE_BOTH
    } dcc_edge_t;
endpackage

// ---- dcc_sync.sv ----
// Two-flop synchroniser for one asynchronous level.
// Assumes the input is an analog comparator decision, free running.
`timescale 1ns/100ps
module dcc_sync (
    input  wire logic clk,      // core clock
    input  wire logic rstN,     // synchronised reset
    input  wire logic asyncIn,  // asynchronous level
    output logic      syncOut   // level in the core domain
);
    logic stage1_ff;
    logic stage2_ff;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            stage1_ff <= 1'b0;
            stage2_ff <= 1'b0;
        end else begin
            stage1_ff <= asyncIn;
            stage2_ff <= stage1_ff;
        end
    end

    assign syncOut = stage2_ff;
endmodule // dcc_sync

// ---- dcc_edge.sv ----
// Edge detector for one comparator result with selectable edges.
// Assumes the input is already synchronised to the clock.
`timescale 1ns/100ps
module dcc_edge
    import dcc_pkg::*;
(
    input  wire logic      clk,      // core clock
    input  wire logic      rstN,     // synchronised reset
    input  wire logic      level,    // polarity-corrected result
    input  wire logic      armed,    // comparator is running
    input  dcc_pkg::dcc_edge_t edgeSel, // edges that raise an event
    output logic           eventOut  // one-cycle event pulse
);
    logic prev_ff;
    logic rise;
    logic fall;

    always_ff @(posedge clk or negedge rstN) begin
        if (!rstN) begin
            prev_ff <= 1'b0;
        end else begin
            prev_ff <= level;
        end
    end

    assign rise = level & ~prev_ff;
    assign fall = ~level & prev_ff;

    always_comb begin
        case (edgeSel)
            DCC_EDGE_RISE: eventOut = armed & rise;            // [RQ6]
            DCC_EDGE_FALL: eventOut = armed & fall;            // [RQ6]
            DCC_EDGE_BOTH: eventOut = armed & (rise | fall);   // [RQ6]
            default:       eventOut = 1'b0;                    // [RQ6]
        endcase
    end
endmodule // dcc_edge

// ---- dcc_top.sv ----
// Control and status logic for two analog comparators, APB slave.
// Assumes the analog comparators, references and pin pads sit outside.
`timescale 1ns/100ps
`include "dcc_regs.svh"

// Behaviour
// [RQ1] Bit 15 enables a comparator; toggling it leaves other fields alone.
// [RQ2] Bit 14 drives the result onto the comparator's output pin.
// [RQ3] Bit 13 inverts the result for the pin and readback bit.
// [RQ4] Inversion also feeds edge detection, so edges swap sense.
// [RQ5] Bit 8 is a read-only mirror of the present result.
// [RQ6] Bits 7-6 pick both, falling, rising or no interrupt edges.
// [RQ7] Bit 4 picks programmable reference or own positive pin.
// [RQ8] Bits 1-0 pick fixed ref, other positive, own positive, own negative.
// [RQ9] Status bit 13 stops both comparators while the system idles.
// [RQ10] Status bits 1 and 0 mirror results of comparator two and one.
// [RQ11] Offsets 0x4, 0x8, 0xC clear, set or invert the written ones.
// [RQ12] Control resets to 00C3, status to zero.
// [RQ13] Software avoids access right after clearing an enable bit.
// [RQ14] Unimplemented bits read zero and ignore writes.
// [RQ15] Results pass two flops; a qualifying edge gives a one-cycle event.
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic        core_clk,        // 25 MHz clock
    input  wire logic        reset_n,         // async reset, active low
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB access phase
    input  wire logic        pwrite,          // APB direction
    input  wire logic [15:0] paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error
    input  wire logic [1:0]  rawResult,       // analog comparator decisions
    input  wire logic        systemIdle,      // system in idle mode
    output logic      [1:0]  compEnable,      // analog comparator power
    output logic      [1:0]  positiveSelect,  // 1: programmable reference
    output logic      [3:0]  negativeSelect,  // two bits per comparator
    output logic      [1:0]  resultOutputPin, // output pin levels
    output logic      [1:0]  resultOutputOe,  // output pin drive enables
    output logic      [1:0]  compEvent,       // one-cycle event requests
    output logic             irq              // level interrupt
);
    logic            rstSync1_ff;
    logic            rstSync2_ff;
    logic            rstN;
    dcc_word_t       ctl_ff [2];
    logic            idleStop_ff;
    logic [1:0]      intStat_ff;
    logic [1:0]      intMask_ff;
    dcc_word_t       prdata_ff;
    logic [1:0]      syncResult;
    logic [1:0]      result;
    logic [1:0]      running;
    logic            wrStrobe;
    logic            rdStrobe;
    logic [1:0]      aliasSel;
    logic [15:0]     baseAddr;
    logic            hitCtl1;
    logic            hitCtl2;
    logic            hitStat;
    logic            hitInt;
    logic            hitMask;
    logic            hitAny;
    logic            aliasOk;
    dcc_word_t       statNext;
    dcc_word_t       maskNext;

    // Reset is released through two flops so all state leaves reset together
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rstSync1_ff <= 1'b0;
            rstSync2_ff <= 1'b0;
        end else begin
            rstSync1_ff <= 1'b1;
            rstSync2_ff <= rstSync1_ff;
        end
    end
    assign rstN = rstSync2_ff;

    // Applies plain, clear, set or invert write to a register image
    function automatic dcc_word_t apply_write(
        input dcc_word_t oldVal,
        input dcc_word_t data,
        input dcc_word_t wmask,
        input logic [1:0] mode
    );
        dcc_word_t newVal;
        begin
            case (mode)
                `DCC_ALIAS_CLR: newVal = oldVal & ~data;         // [RQ11]
                `DCC_ALIAS_SET: newVal = oldVal | data;          // [RQ11]
                `DCC_ALIAS_INV: newVal = oldVal ^ data;          // [RQ11]
                default:        newVal = data;
            endcase
            apply_write = (oldVal & ~wmask) | (newVal & wmask);  // [RQ14]
        end
    endfunction

    // Address decode: low nibble picks the alias, rest picks the register
    assign aliasSel = paddr[3:2];
    assign baseAddr = {paddr[15:4], 4'h0};
    assign hitCtl1  = (baseAddr == `DCC_OFF_CTL1);
    assign hitCtl2  = (baseAddr == `DCC_OFF_CTL2);
    assign hitStat  = (baseAddr == `DCC_OFF_STAT);
    assign hitInt   = (baseAddr == `DCC_OFF_INTSTAT);
    assign hitMask  = (baseAddr == `DCC_OFF_INTMASK);
    assign hitAny   = hitCtl1 | hitCtl2 | hitStat | hitInt | hitMask;
    // Misaligned words and unmapped offsets answer with an error
    assign aliasOk  = hitAny & (paddr[1:0] == 2'h0);

    // Zero-wait slave: every access completes in its first access cycle
    assign pready   = 1'b1;
    assign pslverr  = psel & penable & ~aliasOk;
    assign wrStrobe = psel & penable & pwrite & aliasOk;
    assign rdStrobe = psel & ~penable & ~pwrite;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_comp
            logic hitMine;
            assign hitMine = (gi == 0) ? hitCtl1 : hitCtl2;

            dcc_sync u_sync (
                .clk     (core_clk),
                .rstN    (rstN),
                .asyncIn (rawResult[gi]),
                .syncOut (syncResult[gi])
            );                                                     // [RQ15]

            // Idle stop takes the comparator down without touching its bits
            assign running[gi] = ctl_ff[gi][`DCC_BIT_ENABLE]
                               & ~(idleStop_ff & systemIdle);      // [RQ1] [RQ9]

            // A stopped comparator reports low before the inversion
            assign result[gi] = (syncResult[gi] & running[gi])
                              ^ ctl_ff[gi][`DCC_BIT_INVERT];       // [RQ3]

            dcc_edge u_edge (
                .clk      (core_clk),
                .rstN     (rstN),
                .level    (result[gi]),                            // [RQ4]
                .armed    (running[gi]),
                .edgeSel  (dcc_edge_t'(ctl_ff[gi][`DCC_BIT_EDGEHI:
                                                  `DCC_BIT_EDGELO])),
                .eventOut (compEvent[gi])                          // [RQ15]
            );

            always_ff @(posedge core_clk or negedge rstN) begin
                if (!rstN) begin
                    ctl_ff[gi] <= `DCC_CTL_RESET;                  // [RQ12]
                end else if (wrStrobe && hitMine) begin
                    // Mask keeps writes off the result mirror and unimplemented bits
                    ctl_ff[gi] <= apply_write(ctl_ff[gi], pwdata,
                                              `DCC_CTL_WMASK, aliasSel); // [RQ1]
                end
            end

            assign compEnable[gi]      = running[gi];              // [RQ1]
            assign positiveSelect[gi]  = ctl_ff[gi][`DCC_BIT_POSSEL]; // [RQ7]
            assign negativeSelect[2*gi+1 -: 2] =
                ctl_ff[gi][`DCC_BIT_NEGHI:`DCC_BIT_NEGLO];         // [RQ8]
            // Pin level stays at the result; only the enable gates drive
            assign resultOutputPin[gi] = result[gi];               // [RQ3]
            assign resultOutputOe[gi]  =
                ctl_ff[gi][`DCC_BIT_PINEN] & running[gi];          // [RQ2]
        end
    endgenerate

    // A function result cannot be bit-selected, so images go through nets
    assign statNext = apply_write({18'h0, idleStop_ff, 13'h0}, pwdata,
                                  `DCC_STAT_WMASK, aliasSel);
    assign maskNext = apply_write({30'h0, intMask_ff}, pwdata,
                                  `DCC_INT_WMASK, aliasSel);

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            idleStop_ff <= 1'b0;                                   // [RQ12]
        end else if (wrStrobe && hitStat) begin
            idleStop_ff <= statNext[`DCC_BIT_IDLESTOP];            // [RQ9]
        end
    end

    // Sticky events: a new event wins over a write-one clear
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            intStat_ff <= 2'h0;
        end else if (wrStrobe && hitInt) begin
            intStat_ff <= (intStat_ff & ~pwdata[1:0]) | compEvent;
        end else begin
            intStat_ff <= intStat_ff | compEvent;
        end
    end

    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            intMask_ff <= 2'h0;
        end else if (wrStrobe && hitMask) begin
            intMask_ff <= maskNext[1:0];
        end
    end

    assign irq = |(intStat_ff & intMask_ff);

    // Read data is captured in the setup cycle and held through access
    always_ff @(posedge core_clk or negedge rstN) begin
        if (!rstN) begin
            prdata_ff <= 32'h0000_0000;
        end else if (rdStrobe) begin
            prdata_ff <= 32'h0000_0000;                            // [RQ14]
            // Refused reads return zero even when the base register hits
            if (!aliasOk) begin
                prdata_ff <= 32'h0000_0000;
            end else if (hitCtl1 || hitCtl2) begin
                prdata_ff <= (ctl_ff[hitCtl2 ? 1 : 0] & `DCC_CTL_WMASK)
                           | {23'h0, result[hitCtl2 ? 1 : 0], 8'h0}; // [RQ5]
            end else if (hitStat) begin
                prdata_ff <= {18'h0, idleStop_ff, 11'h0, result}; // [RQ10]
            end else if (hitInt) begin
                prdata_ff <= {30'h0, intStat_ff};
            end else if (hitMask) begin
                prdata_ff <= {30'h0, intMask_ff};
            end
        end
    end

    assign prdata = prdata_ff;
endmodule // dcc_top

// ---- dcc_top_assertions.sv ----
// Concurrent checks on the comparator control ports.
// Assumes it is bound into dcc_top, one clock, reset active low.
`timescale 1ns/100ps
module dcc_top_assertions (
    input logic        core_clk,       // clock
    input logic        reset_n,        // reset
    input logic        psel,           // APB select
    input logic        penable,        // APB access
    input logic        pwrite,         // APB direction
    input logic [15:0] paddr,          // APB address
    input logic [31:0] pwdata,         // APB write data
    input logic        pslverr,        // APB error
    input logic [1:0]  compEnable,     // running
    input logic [1:0]  positiveSelect, // positive input select
    input logic [3:0]  negativeSelect, // negative input selects
    input logic [1:0]  resultOutputOe, // pin enables
    input logic [1:0]  compEvent,      // event pulses
    input logic        irq             // interrupt
);
    logic acc;
    assign acc = psel && penable && pwrite;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    AST_WR_POS: assert property (acc && paddr == 16'hA000 |=>
        positiveSelect[0] == $past(pwdata[4])) else $error("pos sel");
    AST_WR_NEG: assert property (acc && paddr == 16'hA010 |=>
        negativeSelect[3:2] == $past(pwdata[1:0])) else $error("neg sel");
    AST_SET: assert property (acc && paddr == 16'hA008 |=>
        positiveSelect[0] == ($past(positiveSelect[0]) | $past(pwdata[4])))
        else $error("set alias");
    AST_CLR: assert property (acc && paddr == 16'hA004 |=>
        negativeSelect[1:0] == ($past(negativeSelect[1:0])
        & ~$past(pwdata[1:0]))) else $error("clear alias");
    AST_INV: assert property (acc && paddr == 16'hA00C |=>
        negativeSelect[1:0] == ($past(negativeSelect[1:0])
        ^ $past(pwdata[1:0]))) else $error("invert alias");
    AST_OE_RUN: assert property ((resultOutputOe & ~compEnable) == 2'h0)
        else $error("pin driven while stopped");
    AST_EVT_RUN: assert property ((compEvent & ~compEnable) == 2'h0)
        else $error("event while stopped");
    AST_EVT_PULSE: assert property (compEvent[0] |=> !compEvent[0])
        else $error("event longer than one cycle");
    AST_MISALIGN: assert property (psel && penable && paddr[1:0] != 2'h0
        |-> pslverr) else $error("misaligned not refused");
    cover property (compEvent[0]);
    cover property (irq);
    cover property (pslverr);
endmodule // dcc_top_assertions

// ---- tb_dual_comparator_control.sv ----
// Self-checking bench for the comparator control block.
// Assumes dcc_pkg, dcc_top and the checker are compiled before it.
`timescale 1ns/100ps
module tb_dual_comparator_control;
    logic core_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata;
    logic pready, pslverr, systemIdle = 0, irq;
    logic [1:0] rawResult = 0, compEnable, positiveSelect, resultOutputPin;
    logic [1:0] resultOutputOe, compEvent;
    logic [3:0] negativeSelect;
    logic [32:0] qExp[$];
    logic [31:0] ctlM[2];
    logic sidlM = 0, qr, qf;
    int numErrors = 0, samplesChecked = 0, cycles = 0;
    dcc_top i_dut (.core_clk(core_clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rawResult(rawResult), .systemIdle(systemIdle),
        .compEnable(compEnable), .positiveSelect(positiveSelect),
        .negativeSelect(negativeSelect), .resultOutputPin(resultOutputPin),
        .resultOutputOe(resultOutputOe), .compEvent(compEvent), .irq(irq));
    always #20 core_clk = ~core_clk;
    task automatic endOfTest();
        if (numErrors == 0 && samplesChecked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(logic [32:0] seen, logic [32:0] exp);
        samplesChecked++;
        if (seen !== exp) begin
            numErrors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Reads are checked where they complete, against the oldest note
    always @(posedge core_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite)
            chk({pslverr, prdata}, qExp.pop_front());
        cycles++;
        if (cycles == 20000) begin
            numErrors++;
            endOfTest();
        end
    end
    task automatic apb(logic w, logic [15:0] a, logic [31:0] d,
                       logic [32:0] e);
        if (!w) qExp.push_back(e);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1;
        @(posedge core_clk);
        while (pready !== 1'b1) @(posedge core_clk);
        psel <= 0;
        penable <= 0;
        @(posedge core_clk);
    endtask
    task automatic wr(logic [15:0] a, logic [31:0] d);
        apb(1, a, d, 0);
    endtask
    task automatic waitc(int n);
        repeat (n) @(posedge core_clk);
    endtask
    function automatic logic res(int k);
        return (ctlM[k][15] & rawResult[k] & !(sidlM & systemIdle))
            ^ ctlM[k][13];
    endfunction
    function automatic logic [32:0] ctlExp(int k);
        return {1'b0, ctlM[k] | {23'h0, res(k), 8'h00}};
    endfunction
    task automatic rdAll();
        apb(0, 16'hA000, 0, ctlExp(0));
        apb(0, 16'hA010, 0, ctlExp(1));
        apb(0, 16'hA060, 0, {19'h0, sidlM, 11'h0, res(1), res(0)});
    endtask
    initial begin
        logic [31:0] d;
        int k;
        void'($urandom(27));
        ctlM[0] = 32'h0000_00C3;
        ctlM[1] = 32'h0000_00C3;
        repeat (16) @(posedge core_clk);
        reset_n <= 1;
        waitc(3);
        rdAll();
        apb(0, 16'hA040, 0, {1'b1, 32'h0});
        apb(0, 16'hA002, 0, {1'b1, 32'h0});
        wr(16'hA050, 32'hFFFF_FFFF);
        wr(16'hA060, 32'hFFFF_FFFF);
        sidlM = 1;
        rdAll();
        wr(16'hA060, 0);
        sidlM = 0;
        for (int i = 0; i < 8; i++) begin
            rawResult <= 2'($urandom);
            d = $urandom;
            k = i % 2;
            wr(16'hA000 + 16'(k * 16), d);
            ctlM[k] = d & 32'h0000_E0D3;
            waitc(5);
            rdAll();
        end
        for (int m = 1; m < 4; m++) begin
            d = $urandom;
            wr(16'hA000 + 16'(m * 4), d);
            d = d & 32'h0000_E0D3;
            ctlM[0] = m == 1 ? ctlM[0] & ~d : m == 2 ? ctlM[0] | d
                : ctlM[0] ^ d;
            waitc(5);
            rdAll();
        end
        wr(16'hA080, 1);
        for (int e = 0; e < 8; e++) begin
            // A swapped sense turns a raw rise into a falling event
            qr = e[2] ? e[1] : e[0];
            qf = e[2] ? e[0] : e[1];
            rawResult <= 0;
            ctlM[0] = 32'h8000 | 32'(e[1:0]) << 6 | 32'(e[2]) << 13;
            wr(16'hA000, ctlM[0]);
            waitc(6);
            wr(16'hA070, 3);
            rawResult <= 1;
            waitc(6);
            chk(33'(irq), 33'(qr));
            apb(0, 16'hA070, 0, 33'(qr));
            wr(16'hA070, 3);
            rawResult <= 0;
            waitc(6);
            apb(0, 16'hA070, 0, 33'(qf));
            wr(16'hA070, 3);
        end
        wr(16'hA080, 0);
        rawResult <= 1;
        waitc(6);
        chk(33'(irq), 0);
        apb(0, 16'hA070, 0, 1);
        ctlM[0] = 32'hC000;
        wr(16'hA000, ctlM[0]);
        waitc(6);
        chk({compEnable[0], resultOutputOe[0], resultOutputPin[0]}, 7);
        wr(16'hA060, 32'h2000);
        sidlM = 1;
        systemIdle <= 1;
        waitc(2);
        chk({compEnable[0], resultOutputOe[0]}, 0);
        systemIdle <= 0;
        waitc(2);
        chk(33'(compEnable[0]), 1);
        wr(16'hA000, 32'h4000);
        waitc(2);
        chk({compEnable[0], resultOutputOe[0]}, 0);
        waitc(2);
        endOfTest();
    end
endmodule // tb_dual_comparator_control
bind dcc_top dcc_top_assertions u_chk (.core_clk(core_clk),
    .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
    .compEnable(compEnable), .positiveSelect(positiveSelect),
    .negativeSelect(negativeSelect), .resultOutputOe(resultOutputOe),
    .compEvent(compEvent), .irq(irq));
